/* File: hdl/cdsp_pkg.sv */
// package for the correction data serial port
`default_nettype none
package cdsp_pkg;
   localparam int  CDSP_SR_W        = 216;
   localparam int  CDSP_CPY_W       = 17;
   localparam int  CDSP_CPY_LO      = 199;
   localparam int  CDSP_CLK_HZ      = 10_000_000;
   localparam real CDSP_LATCH_MS    = 3.0;
   localparam int  CDSP_LATCH_CYC   = 30000;
   localparam int  CDSP_IDLE_W      = 24;
   localparam int  CDSP_FIFO_W      = 1;
   localparam int  CDSP_FIFO_D      = 8;

   typedef struct packed {
      logic [1:0] ck_sync;
      logic       ck_prev;
      logic [1:0] lat_sync;
      logic       lat_prev;
      logic [1:0] gck_sync;
      logic       gck_prev;
      logic       lat_at_gck;
      logic [CDSP_SR_W-1:0] shreg;
      logic [CDSP_SR_W-1:0] latch;
      logic [CDSP_IDLE_W-1:0] idle_cnt;
      logic       pending;
      logic       sout;
      logic [2:0] din_sync;
      logic [CDSP_CPY_W-1:0] up_s1;
      logic [CDSP_CPY_W-1:0] up_s2;
      logic       upd_q;
   } cdsp_state_t;

   typedef struct packed {
      logic [CDSP_SR_W-1:0] data;
      logic                 strobe;
   } cdsp_latch_t;
endpackage
`default_nettype wire

/* File: hdl/cdsp_fifo.sv */
// small valid/ready fifo for serial input bits
`default_nettype none
module cdsp_fifo #(
   parameter int W = 1,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         sys_rst_i,
   // fill side
   input  wire logic         in_valid_i,
   output logic             in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // drain side
   output logic             out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]     out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp;
   logic [AW:0]  rp;
   logic         full;
   logic         empty;
   assign empty       = (wp == rp);
   assign full        = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem[rp[AW-1:0]];
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (in_valid_i && !full) begin
            wp <= wp + 1'b1;
         end
         if (out_ready_i && !empty) begin
            rp <= rp + 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (in_valid_i && !full) begin
         mem[wp[AW-1:0]] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/cdsp_port.sv */
// correction data serial port: shift register, cascade output, idle auto-latch
// Contract
// - each shift clock rising edge takes the serial input bit into bit 0.
// - each shift clock rising edge moves held bits one place toward the msb.
// - the serial output shows the msb of the shift register.
// - the serial output changes only on shift clock rising edges and on common register loads.
// - after the last edge the 216 bits are copied to the latch 3 to 7 ms later.
// - a common latch edge with select high at the last common clock loads bits 199..215.
`default_nettype none
module cdsp_port
   import cdsp_pkg::*;
#(
   parameter int LATCH_CYC = CDSP_LATCH_CYC
) (
   // clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   sys_rst_i,
   // correction serial link
   input  wire logic                   correction_shift_clock_i,
   input  wire logic                   correction_serial_in_i,
   output logic                        correction_serial_out_o,
   // common register load path
   input  wire logic                   common_shift_clock_i,
   input  wire logic                   common_latch_select_i,
   input  wire logic [CDSP_CPY_W-1:0]  common_upper_bits_i,
   // latched settings
   output logic [CDSP_SR_W-1:0]        correction_latch_o,
   output logic                        latch_update_o,
   // fifo back-pressure seen by the sampling logic
   output logic                        sample_ready_o
);
   cdsp_state_t st;
   cdsp_state_t next_st;
   logic        ck_rise;
   logic        lat_rise;
   logic        gck_rise;
   logic        f_in_ready;
   logic        f_out_valid;
   logic        f_out_data;
   logic        upd;

   assign ck_rise  = st.ck_sync[1] && !st.ck_prev;
   assign lat_rise = st.lat_sync[1] && !st.lat_prev;
   assign gck_rise = st.gck_sync[1] && !st.gck_prev;

   // bits wait here; a full fifo would drop an edge, so the link must stay below core rate
   cdsp_fifo #(
      .W(CDSP_FIFO_W),
      .D(CDSP_FIFO_D)
   ) u_fifo (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .in_valid_i (ck_rise),
      .in_ready_o (f_in_ready),
      .in_data_i  (st.din_sync[2]),
      .out_valid_o(f_out_valid),
      .out_ready_i(1'b1),
      .out_data_o (f_out_data)
   );
   assign sample_ready_o = f_in_ready;

   always_comb begin
      next_st          = st;
      upd              = 1'b0;
      next_st.ck_sync  = {st.ck_sync[0], correction_shift_clock_i};
      next_st.ck_prev  = st.ck_sync[1];
      next_st.lat_sync = {st.lat_sync[0], common_latch_select_i};
      next_st.lat_prev = st.lat_sync[1];
      next_st.gck_sync = {st.gck_sync[0], common_shift_clock_i};
      next_st.gck_prev = st.gck_sync[1];
      // data is delayed one stage more than the clock so it lines up with the edge pulse
      next_st.din_sync = {st.din_sync[1:0], correction_serial_in_i};
      // upper bits are held steady by the host; the select edge is synced just as late
      next_st.up_s1    = common_upper_bits_i;
      next_st.up_s2    = st.up_s1;
      if (gck_rise) begin
         next_st.lat_at_gck = st.lat_sync[1];
      end
      if (f_out_valid) begin
         next_st.shreg = {st.shreg[CDSP_SR_W-2:0], f_out_data};
      end
      if (lat_rise && st.lat_at_gck) begin
         next_st.shreg[CDSP_SR_W-1:CDSP_CPY_LO] = st.up_s2;
      end
      next_st.sout = next_st.shreg[CDSP_SR_W-1];
      if (ck_rise) begin
         next_st.idle_cnt = '0;
         next_st.pending  = 1'b1;
      end else if (st.pending && !f_out_valid) begin
         if (st.idle_cnt >= CDSP_IDLE_W'(LATCH_CYC - 1)) begin
            next_st.latch   = st.shreg;
            next_st.pending = 1'b0;
            upd             = 1'b1;
         end else begin
            next_st.idle_cnt = st.idle_cnt + 1'b1;
         end
      end
      next_st.upd_q = upd;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign correction_serial_out_o = st.sout;
   assign correction_latch_o      = st.latch;
   assign latch_update_o          = st.upd_q;

   property p_shift;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         f_out_valid && !(lat_rise && st.lat_at_gck) |=> st.shreg[0] == $past(f_out_data);
   endproperty
   a_shift: assert property (p_shift) else $error("input bit not captured");
   property p_move;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         f_out_valid && !lat_rise |=> st.shreg[CDSP_SR_W-1:1] == $past(st.shreg[CDSP_SR_W-2:0]);
   endproperty
   a_move: assert property (p_move) else $error("shift did not move");
   property p_msb;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         correction_serial_out_o == st.shreg[CDSP_SR_W-1];
   endproperty
   a_msb: assert property (p_msb) else $error("serial out not msb");
   property p_stable;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         !f_out_valid && !lat_rise |=> $stable(correction_serial_out_o);
   endproperty
   a_stable: assert property (p_stable) else $error("serial out moved without edge");
   sequence s_edge;
      ck_rise;
   endsequence
   property p_noearly;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         s_edge |=> !latch_update_o [*8];
   endproperty
   a_noearly: assert property (p_noearly) else $error("latch too soon");
   property p_cnt;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         upd |-> st.idle_cnt == CDSP_IDLE_W'(LATCH_CYC - 1);
   endproperty
   a_cnt: assert property (p_cnt) else $error("latch at wrong idle time");
   property p_load;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         lat_rise && st.lat_at_gck |=>
            st.shreg[CDSP_SR_W-1:CDSP_CPY_LO] == $past(st.up_s2);
   endproperty
   a_load: assert property (p_load) else $error("common bits not loaded");
   property p_upd;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         latch_update_o |-> correction_latch_o == $past(st.shreg);
   endproperty
   a_upd: assert property (p_upd) else $error("latch content wrong");

   // each edge must reach the shift path, and only the shift path or a common load moves the serial output
   sequence s_fifo_out;
      f_out_valid;
   endsequence
   sequence s_load;
      lat_rise && st.lat_at_gck;
   endsequence
   property p_pipe;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         s_edge |=> s_fifo_out;
   endproperty
   a_pipe: assert property (p_pipe) else $error("edge did not reach the shift path");
   property p_room;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         s_edge |-> sample_ready_o;
   endproperty
   a_room: assert property (p_room) else $error("edge arrived with no room");
   property p_sout_src;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         $changed(correction_serial_out_o) |->
            $past(f_out_valid) || $past(lat_rise && st.lat_at_gck);
   endproperty
   a_sout_src: assert property (p_sout_src) else $error("serial out moved on its own");

   // the latch only moves with its pulse, and the pulse is single
   property p_latch_hold;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         $changed(correction_latch_o) |-> latch_update_o;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch moved without pulse");
   property p_upd_pulse;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         latch_update_o |=> !latch_update_o;
   endproperty
   a_upd_pulse: assert property (p_upd_pulse) else $error("latch pulse too long");
   property p_pend;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         latch_update_o |-> !st.pending;
   endproperty
   a_pend: assert property (p_pend) else $error("copy still pending after latch");
   property p_restart;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         s_edge |=> st.pending && st.idle_cnt == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("edge did not restart idle time");
   // the counter never runs past the copy point, so a stuck compare shows here
   property p_bound;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         st.pending |-> st.idle_cnt <= CDSP_IDLE_W'(LATCH_CYC - 1);
   endproperty
   a_bound: assert property (p_bound) else $error("idle count overran");

   // common register load path
   property p_cap;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         gck_rise |=> st.lat_at_gck == $past(st.lat_sync[1]);
   endproperty
   a_cap: assert property (p_cap) else $error("select level not captured");
   property p_noload;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         lat_rise && !st.lat_at_gck && !f_out_valid |=> $stable(st.shreg);
   endproperty
   a_noload: assert property (p_noload) else $error("load without select");
   property p_load_msb;
      @(posedge core_clk_i) disable iff (sys_rst_i)
         s_load |=> correction_serial_out_o == $past(st.up_s2[CDSP_CPY_W-1]);
   endproperty
   a_load_msb: assert property (p_load_msb) else $error("loaded msb not shown");
endmodule
`default_nettype wire

/* File: bench/cdsp_host.sv */
// host model driving the correction serial link
`default_nettype none
module cdsp_host (
   // link toward the port
   output logic sck_o,
   output logic sin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sck_o = 1'b0;
      sin_o = 1'b0;
   end
   // first bit sent ends up in the msb; clock rests low between frames
   task automatic send(input logic [215:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         sin_o = v[i];
         #400 sck_o = 1'b1;
         #400 sck_o = 1'b0;
      end
      // a released data line must not keep showing the last bit
      sin_o = ~sin_o;
   endtask
endmodule
`default_nettype wire

/* File: bench/test_correction_data_serial_port.sv */
// self-checking bench for the correction data serial port
`default_nettype none
module test_correction_data_serial_port;
   import cdsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LC = 50;
   logic                  core_clk_i = 1'b0;
   logic                  sys_rst_i;
   logic                  sck;
   logic                  sin;
   logic                  sout;
   logic                  gck;
   logic                  gsel;
   logic                  upd;
   logic                  rdy;
   logic [CDSP_CPY_W-1:0] upper;
   logic [CDSP_SR_W-1:0]  latch;
   logic [CDSP_SR_W-1:0]  pat;
   int                    failures;
   int                    checked;

   cdsp_host host (.sck_o(sck), .sin_o(sin));
   cdsp_port #(.LATCH_CYC(LC)) DUT (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .correction_shift_clock_i(sck), .correction_serial_in_i(sin),
      .correction_serial_out_o(sout), .common_shift_clock_i(gck),
      .common_latch_select_i(gsel), .common_upper_bits_i(upper),
      .correction_latch_o(latch), .latch_update_o(upd), .sample_ready_o(rdy));

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkv(input logic [CDSP_SR_W-1:0] got, input logic [CDSP_SR_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // bounded wait for the auto-latch pulse, returns cycles waited
   task automatic wait_latch(output int n);
      n = 0;
      while (upd !== 1'b1 && n < 200) begin
         @(negedge core_clk_i);
         n++;
      end
   endtask

   task automatic t_shift_latch;
      int   n;
      logic s;
      pat = {{26{8'ha5}}, 8'h3c};
      host.send(pat, CDSP_SR_W);
      repeat (4) @(negedge core_clk_i);
      s = sout;
      chk1(sout, pat[CDSP_SR_W-1]);
      chk1(rdy, 1'b1);
      chkv(latch, '0);
      wait_latch(n);
      chk1(sout, s);
      chk1(n >= LC - 15 && n <= LC + 10, 1'b1);
      chkv(latch, pat);
   endtask

   // upper bit 16 differs from the old msb so a missed load shows
   task automatic t_common_load;
      int n;
      // stay well past the scaled 7 ms after the last serial write before any select edge
      repeat (2 * LC) @(negedge core_clk_i);
      upper = 17'h0a5c3;
      gsel = 1'b1;
      gck = 1'b1;
      repeat (4) @(negedge core_clk_i);
      gck = 1'b0;
      gsel = 1'b0;
      repeat (4) @(negedge core_clk_i);
      gsel = 1'b1;
      repeat (6) @(negedge core_clk_i);
      chk1(sout, upper[16]);
      host.send(216'h0, 1);
      repeat (6) @(negedge core_clk_i);
      chk1(sout, upper[15]);
      wait_latch(n);
      chk1(n >= LC - 15 && n <= LC + 10, 1'b1);
      chkv(latch, {upper[15:0], pat[CDSP_CPY_LO-1:0], 1'b0});
      gsel = 1'b0;
   endtask

   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   initial begin
      failures = 0;
      checked = 0;
      sys_rst_i = 1'b1;
      gck = 1'b0;
      gsel = 1'b0;
      upper = '0;
      repeat (2) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      chkv(latch, '0);
      chk1(upd, 1'b0);
      chk1(rdy, 1'b1);
      repeat (4) @(negedge core_clk_i);
      t_shift_latch();
      t_common_load();
      conclude();
   end
   // whole run needs about 0.2 ms of link traffic and idle time
   initial begin
      #1_000_000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
